// ==== rtl/bhm_consts.svh ====
// constants for the byte hardware multiplier
`ifndef BHM_CONSTS_SVH
`define BHM_CONSTS_SVH
`define BHM_OPERAND_W    8
`define BHM_PRODUCT_W    16
`define BHM_HIGH_LSB     8
`define BHM_PROD_RESET   16'h0000
`define BHM_STATUS_W     8
`define BHM_STATUS_RESET 8'h00
`define BHM_MUL_CYCLES   1
`endif

// ==== rtl/bhm_pkg.sv ====
// types shared by the byte hardware multiplier
`include "bhm_consts.svh"
package bhm_pkg;
    typedef logic [`BHM_OPERAND_W-1:0] bhm_byte_t;

    // multiply request from the core
    typedef struct packed {
        logic      valid;
        bhm_byte_t working_register;
        bhm_byte_t file_register;
    } bhm_mul_req_s;

    // direct software write to the product pair
    typedef struct packed {
        logic      wr_high;
        logic      wr_low;
        bhm_byte_t data;
    } bhm_prod_wr_s;

    // product register pair as seen by the core
    typedef struct packed {
        bhm_byte_t product_high;
        bhm_byte_t product_low;
    } bhm_prod_s;
endpackage : bhm_pkg

// ==== rtl/bhm_multiplier.sv ====
// single-cycle 8x8 unsigned multiplier with product register pair
`include "bhm_consts.svh"

module bhm_multiplier #(
    parameter int OPERAND_W = `BHM_OPERAND_W
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  resetn_i,
    input  wire bhm_pkg::bhm_mul_req_s mul_req_i,
    input  wire bhm_pkg::bhm_prod_wr_s prod_wr_i,
    input  wire logic [7:0]            alu_status_i,
    output logic [7:0]                 alu_status_o,
    output bhm_pkg::bhm_prod_s         prod_o,
    output logic                       mul_done_o
);
    import bhm_pkg::*;

    // the packed types fix the width; other widths are refused
    if (OPERAND_W != `BHM_OPERAND_W) begin : g_width_check
        $error("bhm_multiplier: only 8-bit operands are supported");
    end

    // zero-extended product, no truncation possible at 16 bits
    function automatic logic [`BHM_PRODUCT_W-1:0] umul8(input bhm_byte_t a,
                                                       input bhm_byte_t b);
        umul8 = {8'h00, a} * {8'h00, b};
    endfunction : umul8

    bhm_prod_s  prod_reg;
    bhm_prod_s  prod_next;
    logic       done_reg;
    logic       done_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [`BHM_PRODUCT_W-1:0] mul_full;

    // multiply and writes; multiply wins over a same-cycle direct write
    always_comb begin
        mul_full    = umul8(mul_req_i.working_register,
                            mul_req_i.file_register);
        prod_next   = prod_reg; // hold between updates
        done_next   = mul_req_i.valid;
        status_next = alu_status_i; // multiply never touches flags
        if (mul_req_i.valid) begin
            prod_next.product_high = mul_full[`BHM_PRODUCT_W-1:`BHM_HIGH_LSB];
            prod_next.product_low  = mul_full[`BHM_HIGH_LSB-1:0];
        end else begin
            if (prod_wr_i.wr_high) begin
                prod_next.product_high = prod_wr_i.data;
            end
            if (prod_wr_i.wr_low) begin
                prod_next.product_low = prod_wr_i.data;
            end
        end
    end

    // registered in the same cycle the request is seen
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            prod_reg   <= `BHM_PROD_RESET;
            done_reg   <= 1'b0;
            status_reg <= `BHM_STATUS_RESET;
        end else begin
            prod_reg   <= prod_next;
            done_reg   <= done_next;
            status_reg <= status_next;
        end
    end

    // outputs come straight from the registers, no logic after them
    assign prod_o       = prod_reg;
    assign mul_done_o   = done_reg;
    assign alu_status_o = status_reg;

    // checks
    // full product visible one cycle after the request
    property p_product_one_cycle;
        @(posedge core_clk_i) disable iff (!resetn_i)
        mul_req_i.valid |=> prod_o == umul8($past(mul_req_i.working_register),
                                            $past(mul_req_i.file_register));
    endproperty
    a_product_one_cycle: assert property (p_product_one_cycle)
        else $error("product not ready one cycle after multiply");

    // upper half of the product lands in the high register
    property p_high_byte;
        @(posedge core_clk_i) disable iff (!resetn_i)
        mul_req_i.valid |=> prod_o.product_high ==
            8'(({8'h00, $past(mul_req_i.working_register)} *
                {8'h00, $past(mul_req_i.file_register)}) >> 8);
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("high product byte wrong");

    // largest operands must keep the top bits
    property p_no_trunc;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (mul_req_i.valid && mul_req_i.working_register == 8'hFF &&
         mul_req_i.file_register == 8'hFF) |=> prod_o == 16'hFE01;
    endproperty
    a_no_trunc: assert property (p_no_trunc)
        else $error("largest product truncated");

    // multiply leaves the flags copy alone
    property p_flags_kept;
        @(posedge core_clk_i) disable iff (!resetn_i)
        mul_req_i.valid |=> alu_status_o == $past(alu_status_i);
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("status flags changed by multiply");

    // zero in the working register always gives zero
    property p_operand_source;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (mul_req_i.valid && mul_req_i.working_register == 8'h00) |=> prod_o == 16'h0000;
    endproperty
    a_operand_source: assert property (p_operand_source)
        else $error("zero working register gave nonzero product");

    // idle cycles leave the pair untouched
    property p_hold;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (!mul_req_i.valid && !prod_wr_i.wr_high && !prod_wr_i.wr_low)
            |=> $stable(prod_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("product pair changed without cause");

    // done drops once requests stop
    property p_done_pulse;
        @(posedge core_clk_i) disable iff (!resetn_i)
        mul_req_i.valid ##1 !mul_req_i.valid |=> !mul_done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done stretched past one cycle");

    // low-only write leaves the high byte alone
    property p_low_write;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (!mul_req_i.valid && prod_wr_i.wr_low && !prod_wr_i.wr_high)
            |=> prod_o.product_low == $past(prod_wr_i.data) &&
                prod_o.product_high == $past(prod_o.product_high);
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("direct low write wrong");

    // done is exactly the request one cycle late, never stretched
    property p_done_exact;
        @(posedge core_clk_i) disable iff (!resetn_i)
        1'b1 |=> mul_done_o == $past(mul_req_i.valid);
    endproperty
    a_done_exact: assert property (p_done_exact)
        else $error("done does not follow the multiply request");

    // low half of the product lands in the low register
    property p_low_byte;
        @(posedge core_clk_i) disable iff (!resetn_i)
        mul_req_i.valid |=> prod_o.product_low ==
            8'($past(mul_req_i.working_register) * $past(mul_req_i.file_register));
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low product byte wrong");

    // a multiply beats a direct write in the same cycle
    property p_mul_wins;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (mul_req_i.valid && (prod_wr_i.wr_high || prod_wr_i.wr_low))
            |=> prod_o == ({8'h00, $past(mul_req_i.working_register)} *
                           {8'h00, $past(mul_req_i.file_register)});
    endproperty
    a_mul_wins: assert property (p_mul_wins)
        else $error("direct write overrode a multiply");

    // high-only write leaves the low byte alone
    property p_high_write;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (!mul_req_i.valid && prod_wr_i.wr_high && !prod_wr_i.wr_low)
            |=> prod_o.product_high == $past(prod_wr_i.data) &&
                prod_o.product_low == $past(prod_o.product_low);
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("direct high write wrong");

    // both enables put the same byte into both halves
    property p_both_write;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (!mul_req_i.valid && prod_wr_i.wr_high && prod_wr_i.wr_low)
            |=> prod_o == {2{$past(prod_wr_i.data)}};
    endproperty
    a_both_write: assert property (p_both_write)
        else $error("direct write to both bytes wrong");

    // flags copy follows its input every cycle, multiply or not
    property p_status_follow;
        @(posedge core_clk_i) disable iff (!resetn_i)
        1'b1 |=> alu_status_o == $past(alu_status_i);
    endproperty
    a_status_follow: assert property (p_status_follow)
        else $error("status copy does not follow its input");

    // synchronous reset clears every output on the next edge
    property p_reset_clear;
        @(posedge core_clk_i)
        !resetn_i |=> (prod_o == `BHM_PROD_RESET && !mul_done_o &&
                       alu_status_o == `BHM_STATUS_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared by reset");

    c_mul:      cover property (@(posedge core_clk_i) mul_req_i.valid);
    c_back2back: cover property (@(posedge core_clk_i)
        mul_req_i.valid ##1 mul_req_i.valid);
    c_max:      cover property (@(posedge core_clk_i) prod_o == 16'hFE01);
    c_wr_high:  cover property (@(posedge core_clk_i)
        !mul_req_i.valid && prod_wr_i.wr_high);
    c_wr_both:  cover property (@(posedge core_clk_i)
        !mul_req_i.valid && prod_wr_i.wr_high && prod_wr_i.wr_low);
endmodule : bhm_multiplier

// ==== bench/bhm_core_model.sv ====
// core software model: signed fixup of the unsigned product
module bhm_core_model (
    input  wire logic [7:0]  first_operand_i,
    input  wire logic [7:0]  second_operand_i,
    input  wire logic [7:0]  product_high_i,
    input  wire logic [15:0] part_high_i,
    input  wire logic [15:0] part_cross_a_i,
    input  wire logic [15:0] part_cross_b_i,
    input  wire logic [15:0] part_low_i,
    output logic      [7:0]  signed_high_o,
    output logic      [31:0] wide_result_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // subtract each operand when the other one is negative
    assign signed_high_o = product_high_i
        - (second_operand_i[7] ? first_operand_i : 8'h00)
        - (first_operand_i[7] ? second_operand_i : 8'h00);
    // software sum of four byte products into the wide result
    assign wide_result_o = {part_high_i, 16'h0000}
        + {8'h00, part_cross_a_i, 8'h00}
        + {8'h00, part_cross_b_i, 8'h00}
        + {16'h0000, part_low_i};
endmodule : bhm_core_model

// ==== bench/byte_hardware_multiplier_bench.sv ====
// self-checking bench for the byte hardware multiplier
module byte_hardware_multiplier_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import bhm_pkg::*;
    logic         core_clk_i;
    logic         resetn_i;
    bhm_mul_req_s req;
    bhm_prod_wr_s wr;
    logic [7:0]   st_in;
    logic [7:0]   st_out;
    bhm_prod_s    prod;
    logic         done;
    logic [7:0]   sgn_high;
    logic [15:0]  part_hh;
    logic [15:0]  part_hl;
    logic [15:0]  part_lh;
    logic [15:0]  part_ll;
    logic [31:0]  wide_result;
    int           n_errors;
    int           num_checks;
    bhm_multiplier i_bhm_multiplier (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .mul_req_i(req), .prod_wr_i(wr), .alu_status_i(st_in),
        .alu_status_o(st_out), .prod_o(prod), .mul_done_o(done));
    bhm_core_model i_bhm_core_model (.first_operand_i(req.working_register),
        .second_operand_i(req.file_register), .product_high_i(prod.product_high),
        .part_high_i(part_hh), .part_cross_a_i(part_hl), .part_cross_b_i(part_lh),
        .part_low_i(part_ll), .signed_high_o(sgn_high), .wide_result_o(wide_result));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // one multiply; a clashing direct write must lose
    task automatic mul_one(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
        logic signed [15:0] sp;
        sp = $signed(a) * $signed(b);
        @(posedge core_clk_i);
        req <= '{1'b1, a, b};
        wr <= '{1'b1, 1'b1, ~a};
        st_in <= s;
        @(posedge core_clk_i);
        req.valid <= 1'b0;
        wr <= '0;
        #1;
        check(prod, {8'h00, a} * {8'h00, b});
        check(done, 1'b1);
        check(st_out, s);
        check(sgn_high, sp[15:8]);
    endtask : mul_one
    // back to back multiplies, then hold and direct writes
    task automatic b2b_hold;
        @(posedge core_clk_i);
        req <= '{1'b1, 8'hFF, 8'h02};
        @(posedge core_clk_i);
        req <= '{1'b1, 8'h10, 8'h10};
        #1 check(prod, 16'h01FE);
        @(posedge core_clk_i);
        req.valid <= 1'b0;
        #1 check({done, prod}, 17'h1_0100);
        repeat (3) @(posedge core_clk_i);
        #1 check({done, prod}, 17'h0_0100);
        @(posedge core_clk_i);
        wr <= '{1'b0, 1'b1, 8'hAB};
        @(posedge core_clk_i);
        wr <= '{1'b1, 1'b1, 8'h5C};
        #1 check(prod, 16'h01AB);
        @(posedge core_clk_i);
        wr <= '{1'b1, 1'b0, 8'h3A};
        #1 check(prod, 16'h5C5C);
        @(posedge core_clk_i);
        wr <= '0;
        #1 check(prod, 16'h3A5C);
    endtask : b2b_hold
    // reset in mid-run clears pair, flags copy and done
    task automatic mid_reset;
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        st_in <= 8'h5A;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        #1 check({done, st_out, prod}, 25'h0);
        @(posedge core_clk_i);
        #1 check(st_out, 8'h5A);
    endtask : mid_reset
    // one multiply through the block, product handed back
    task automatic mul_get(input logic [7:0] a, input logic [7:0] b, output logic [15:0] p);
        @(posedge core_clk_i);
        req <= '{1'b1, a, b};
        @(posedge core_clk_i);
        req.valid <= 1'b0;
        #1 p = prod;
    endtask : mul_get
    // 16x16 product assembled by software from four byte multiplies
    task automatic mul_wide(input logic [15:0] x, input logic [15:0] y);
        mul_get(x[15:8], y[15:8], part_hh);
        mul_get(x[15:8], y[7:0], part_hl);
        mul_get(x[7:0], y[15:8], part_lh);
        mul_get(x[7:0], y[7:0], part_ll);
        #1 check(wide_result, {16'h0000, x} * {16'h0000, y});
    endtask : mul_wide
    initial begin
        n_errors = 0;
        num_checks = 0;
        resetn_i = 1'b0;
        req = '0;
        wr = '0;
        st_in = 8'h00;
        repeat (3) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        #1 check({done, st_out, prod}, 25'h0);
        mul_one(8'hFF, 8'hFF, 8'hA5);
        mul_one(8'h00, 8'h80, 8'hFF);
        mul_one(8'h80, 8'h7F, 8'h00);
        mul_one(8'h05, 8'h07, 8'h3C);
        b2b_hold();
        mid_reset();
        mul_wide(16'hFFFF, 16'hFFFF);
        mul_wide(16'h1234, 16'hABCD);
        end_of_test();
    end
endmodule : byte_hardware_multiplier_bench
